// ==== common/vps_pkg.sv ====
// shared constants, register map and bus carriers for the virtual pin routing block
package vps_pkg;

  // ==========================================================================
  // pin space
  localparam int VPS_SEL_W = 8;            // width of one pin selector field
  localparam int VPS_PIN_COUNT = 256;      // every selector code names one pin index
  localparam int VPS_VPIN_COUNT = 6;       // virtual pins per core
  localparam int VPS_INTERNAL_FIRST = 1;   // first index tied to internal core signals
  localparam int VPS_INTERNAL_COUNT = 13;  // indices 1 to 13
  localparam int VPS_PAD_BASE = 14;        // first index that samples a package pad
  localparam int VPS_SLAVE_VPIN_BASE = 170;  // indices 170 to 175
  localparam int VPS_MASTER_VPIN_BASE = 176; // indices 176 to 181

  // ==========================================================================
  // register map, byte addresses on the register bus
  localparam int VPS_ADDR_W = 8;
  localparam logic [VPS_ADDR_W-1:0] VPS_OFS_SEL7 = 8'h00;
  localparam logic [VPS_ADDR_W-1:0] VPS_OFS_SEL8 = 8'h04;
  localparam logic [VPS_ADDR_W-1:0] VPS_OFS_VOUT_LO = 8'h08;
  localparam logic [VPS_ADDR_W-1:0] VPS_OFS_VOUT_HI = 8'h0C;
  localparam logic [VPS_ADDR_W-1:0] VPS_OFS_STATUS = 8'h10;

  // field positions inside the two input select registers
  localparam int VPS_CAPTURE_LSB = 8;      // bits 15-8
  localparam int VPS_TIMER_CLK_LSB = 0;    // bits 7-0

  // reset values
  localparam logic [15:0] VPS_SEL7_RESET = 16'h0000;
  localparam logic [15:0] VPS_SEL8_RESET = 16'h0000;
  localparam logic [47:0] VPS_VOUT_RESET = 48'h0000_0000_0000;

  // bus responses
  localparam logic [1:0] VPS_RESP_OKAY = 2'h0;
  localparam logic [1:0] VPS_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // register bus carriers, master to slave and slave to master
  typedef struct packed {
    logic awvalid;
    logic [VPS_ADDR_W-1:0] awaddr;
    logic [2:0] awprot;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [VPS_ADDR_W-1:0] araddr;
    logic [2:0] arprot;
    logic rready;
  } vps_axil_m2s_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vps_axil_s2m_type;

endpackage : vps_pkg

// ==== core/vps_pad_sync.sv ====
// two stage synchroniser for the package pads that feed the pin space
`timescale 1ns/1ps
`default_nettype none

module vps_pad_sync #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pads and their synchronised copy
  input wire logic [WIDTH-1:0] pad_in,
  output logic [WIDTH-1:0] pad_sync
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } vps_sync_state_type;

  vps_sync_state_type state_q;
  vps_sync_state_type state_d;

  if (WIDTH < 1) begin : g_check
    $error("vps_pad_sync needs at least one pad");
  end

  // first stage is only read by the second, never by routing logic
  always_comb begin
    state_d.first = pad_in;
    state_d.second = state_q.first;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign pad_sync = state_q.second;

endmodule : vps_pad_sync

`default_nettype wire

// ==== core/vps_pin_mux.sv ====
// one selector: picks the pin whose index equals the selector code
`timescale 1ns/1ps
`default_nettype none

module vps_pin_mux
  import vps_pkg::*;
#(
  parameter int SEL_W = 8,
  parameter int PIN_COUNT = 256
) (
  // whole pin space
  input wire logic [PIN_COUNT-1:0] pins,
  // selector code and routed level
  input wire logic [SEL_W-1:0] sel,
  output logic routed
);

  // every code must name a pin, so no out-of-range index can occur
  if (PIN_COUNT != (1 << SEL_W)) begin : g_check
    $error("vps_pin_mux needs one pin per selector code");
  end

  // identity mapping from code to pin index
  assign routed = pins[sel]; // see [RQ13]

endmodule : vps_pin_mux

`default_nettype wire

// ==== core/vps_routing.sv ====
// virtual pin routing with capture and timer clock input selection behind a register bus
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [RQ1] six master virtual pins 176-181 select exactly like ordinary remappable pins
// [RQ2] virtual pins stay inside the chip; no pad is driven or sampled by them
// [RQ3] a peripheral output placed on a virtual pin can feed another peripheral input
// [RQ4] slave fabric receives master virtual outputs 5..0 as its inputs 175..170
// [RQ5] pin indices 1 to 13 carry internal signals from both cores
// [RQ6] pins 181 down to 176 carry master virtual outputs 5 down to 0
// [RQ7] pins 175 down to 170 carry slave virtual outputs 5 down to 0
// [RQ8] slave transmitter reaches master receiver through a virtual pin, no pad used
// [RQ9] seventh select register bits 15-8 choose capture unit 5 capture input
// [RQ10] seventh select register bits 7-0 choose capture unit 5 timer clock input
// [RQ11] eighth select register bits 15-8 choose capture unit 6 capture input
// [RQ12] eighth select register bits 7-0 choose capture unit 6 timer clock input
// [RQ13] selector value routes the pin with that same index
module vps_routing
  import vps_pkg::*;
#(
  parameter int NUM_PADS = 32,
  parameter int NUM_PERIPH_OUT = 32
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire vps_pkg::vps_axil_m2s_type axil_m2s,
  output vps_pkg::vps_axil_s2m_type axil_s2m,
  // package pads, asynchronous to aclk
  input wire logic [NUM_PADS-1:0] remappable_pin,
  // internal signals from both cores for pin indices 1 to 13
  input wire logic [VPS_INTERNAL_COUNT-1:0] core_internal_pin,
  // master peripheral outputs that may be placed on a virtual pin
  input wire logic [NUM_PERIPH_OUT-1:0] periph_out,
  // slave fabric virtual outputs 5..0, same clock
  input wire logic [VPS_VPIN_COUNT-1:0] slave_virtual_remap_output,
  // master virtual outputs handed to the slave fabric as its inputs 175..170
  output logic [VPS_VPIN_COUNT-1:0] slave_fabric_virtual_in,
  // routed peripheral inputs
  output logic capture5_input,
  output logic timer5_clock_input,
  output logic capture6_input,
  output logic timer6_clock_input
);
  import vps_pkg::*;

  // ==========================================================================
  // elaboration checks
  if (VPS_PAD_BASE + NUM_PADS > VPS_SLAVE_VPIN_BASE) begin : g_pad_check
    $error("vps_routing: pads would overlap the virtual pin indices");
  end
  if (NUM_PERIPH_OUT < 1 || NUM_PERIPH_OUT > VPS_PIN_COUNT - 1) begin : g_out_check
    $error("vps_routing: peripheral output count must be 1 to 255");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    logic [VPS_ADDR_W-1:0] aw_addr;
    logic aw_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_have;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] sel7;                // input_select_reg_seven
    logic [15:0] sel8;                // input_select_reg_eight
    logic [47:0] vout_sel;            // one byte per master virtual pin
    logic [3:0] routed;               // capture5, timer5, capture6, timer6
    logic [VPS_VPIN_COUNT-1:0] slave_vin;
  } vps_top_state_type;

  vps_top_state_type state_q;
  vps_top_state_type state_d;

  // ==========================================================================
  // pad synchroniser
  logic [NUM_PADS-1:0] pad_sync;

  vps_pad_sync #(
    .WIDTH(NUM_PADS)
  ) u_pad_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pad_in(remappable_pin),
    .pad_sync(pad_sync)
  );

  // ==========================================================================
  // master virtual pins
  logic [VPS_PIN_COUNT-1:0] periph_space;
  logic [VPS_VPIN_COUNT-1:0] master_vpin;

  // code 0 leaves a virtual pin low, code k carries peripheral output k-1
  always_comb begin
    periph_space = '0;
    periph_space[NUM_PERIPH_OUT:1] = periph_out;
  end

  for (genvar g = 0; g < VPS_VPIN_COUNT; g++) begin : g_vpin
    logic [VPS_SEL_W-1:0] out_code;
    assign out_code = state_q.vout_sel[g*VPS_SEL_W +: VPS_SEL_W];
    // a virtual pin behaves as any pin output, but has no pad driver at all
    assign master_vpin[g] = periph_space[out_code]; // see [RQ1] see [RQ2] see [RQ3]
  end

  // ==========================================================================
  // pin space seen by every input selector
  logic [VPS_PIN_COUNT-1:0] pin_space;

  // index 0 and all unused indices read low
  always_comb begin
    pin_space = '0;
    pin_space[VPS_INTERNAL_FIRST +: VPS_INTERNAL_COUNT] = core_internal_pin; // see [RQ5]
    pin_space[VPS_PAD_BASE +: NUM_PADS] = pad_sync;
    // slave virtual outputs 5..0 land on 175..170, lets a slave transmitter feed us
    pin_space[VPS_SLAVE_VPIN_BASE +: VPS_VPIN_COUNT] = slave_virtual_remap_output; // see [RQ7] see [RQ8]
    // master virtual outputs 5..0 land on 181..176, fed back without a pad
    pin_space[VPS_MASTER_VPIN_BASE +: VPS_VPIN_COUNT] = master_vpin; // see [RQ6] see [RQ3]
  end

  // ==========================================================================
  // the four peripheral input selectors
  logic [3:0] routed_now;

  vps_pin_mux #(
    .SEL_W(VPS_SEL_W),
    .PIN_COUNT(VPS_PIN_COUNT)
  ) u_mux_cap5 (
    .pins(pin_space),
    .sel(state_q.sel7[VPS_CAPTURE_LSB +: VPS_SEL_W]), // see [RQ9]
    .routed(routed_now[3])
  );

  vps_pin_mux #(
    .SEL_W(VPS_SEL_W),
    .PIN_COUNT(VPS_PIN_COUNT)
  ) u_mux_tck5 (
    .pins(pin_space),
    .sel(state_q.sel7[VPS_TIMER_CLK_LSB +: VPS_SEL_W]), // see [RQ10]
    .routed(routed_now[2])
  );

  vps_pin_mux #(
    .SEL_W(VPS_SEL_W),
    .PIN_COUNT(VPS_PIN_COUNT)
  ) u_mux_cap6 (
    .pins(pin_space),
    .sel(state_q.sel8[VPS_CAPTURE_LSB +: VPS_SEL_W]), // see [RQ11]
    .routed(routed_now[1])
  );

  vps_pin_mux #(
    .SEL_W(VPS_SEL_W),
    .PIN_COUNT(VPS_PIN_COUNT)
  ) u_mux_tck6 (
    .pins(pin_space),
    .sel(state_q.sel8[VPS_TIMER_CLK_LSB +: VPS_SEL_W]), // see [RQ12]
    .routed(routed_now[0])
  );

  // ==========================================================================
  // byte lane merge for register writes
  function automatic logic [31:0] vps_merge(input logic [31:0] old_val,
                                            input logic [31:0] new_val,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction : vps_merge

  // ==========================================================================
  // bus handshakes; address and data are taken in either order
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic aw_now;
  logic w_now;
  logic [VPS_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // one write and one read in flight; a pending response blocks new requests
  assign axil_s2m.awready = !state_q.aw_have && !state_q.bvalid;
  assign axil_s2m.wready = !state_q.w_have && !state_q.bvalid;
  assign axil_s2m.arready = !state_q.rvalid;
  assign axil_s2m.bvalid = state_q.bvalid;
  assign axil_s2m.bresp = state_q.bresp;
  assign axil_s2m.rvalid = state_q.rvalid;
  assign axil_s2m.rresp = state_q.rresp;
  assign axil_s2m.rdata = state_q.rdata;

  assign aw_take = axil_m2s.awvalid && axil_s2m.awready;
  assign w_take = axil_m2s.wvalid && axil_s2m.wready;
  assign ar_take = axil_m2s.arvalid && axil_s2m.arready;
  assign aw_now = state_q.aw_have || aw_take;
  assign w_now = state_q.w_have || w_take;
  assign wr_addr = state_q.aw_have ? state_q.aw_addr : axil_m2s.awaddr;
  assign wr_data = state_q.w_have ? state_q.w_data : axil_m2s.wdata;
  assign wr_strb = state_q.w_have ? state_q.w_strb : axil_m2s.wstrb;

  // ==========================================================================
  // next state
  always_comb begin
    logic [31:0] merged;
    merged = '0;
    state_d = state_q;

    // hold a lone address or data beat until its partner arrives
    if (aw_take) begin
      state_d.aw_addr = axil_m2s.awaddr;
      state_d.aw_have = 1'b1;
    end
    if (w_take) begin
      state_d.w_data = axil_m2s.wdata;
      state_d.w_strb = axil_m2s.wstrb;
      state_d.w_have = 1'b1;
    end

    // write completes when both halves are present
    if (aw_now && w_now && !state_q.bvalid) begin
      state_d.aw_have = 1'b0;
      state_d.w_have = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = VPS_RESP_OKAY;
      unique case (wr_addr & ~8'h03)
        VPS_OFS_SEL7: begin
          merged = vps_merge({16'h0000, state_q.sel7}, wr_data, wr_strb);
          state_d.sel7 = merged[15:0]; // see [RQ9] see [RQ10]
        end
        VPS_OFS_SEL8: begin
          merged = vps_merge({16'h0000, state_q.sel8}, wr_data, wr_strb);
          state_d.sel8 = merged[15:0]; // see [RQ11] see [RQ12]
        end
        VPS_OFS_VOUT_LO: begin
          state_d.vout_sel[31:0] = vps_merge(state_q.vout_sel[31:0], wr_data, wr_strb);
        end
        VPS_OFS_VOUT_HI: begin
          merged = vps_merge({16'h0000, state_q.vout_sel[47:32]}, wr_data, wr_strb);
          state_d.vout_sel[47:32] = merged[15:0];
        end
        default: begin
          state_d.bresp = VPS_RESP_SLVERR; // status and unmapped words take no write
        end
      endcase
    end else if (state_q.bvalid && axil_m2s.bready) begin
      state_d.bvalid = 1'b0;
    end

    // read answer is registered one cycle after the address is taken
    if (ar_take) begin
      state_d.rvalid = 1'b1;
      state_d.rresp = VPS_RESP_OKAY;
      unique case (axil_m2s.araddr & ~8'h03)
        VPS_OFS_SEL7: state_d.rdata = {16'h0000, state_q.sel7};
        VPS_OFS_SEL8: state_d.rdata = {16'h0000, state_q.sel8};
        VPS_OFS_VOUT_LO: state_d.rdata = state_q.vout_sel[31:0];
        VPS_OFS_VOUT_HI: state_d.rdata = {16'h0000, state_q.vout_sel[47:32]};
        VPS_OFS_STATUS: begin
          state_d.rdata = {16'h0000, state_q.slave_vin, master_vpin, state_q.routed};
        end
        default: begin
          state_d.rdata = 32'h0000_0000;
          state_d.rresp = VPS_RESP_SLVERR;
        end
      endcase
    end else if (state_q.rvalid && axil_m2s.rready) begin
      state_d.rvalid = 1'b0;
    end

    // routed levels leave through flip-flops
    state_d.routed = routed_now;
    state_d.slave_vin = master_vpin; // see [RQ4]
  end

  // ==========================================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= '0;
      state_q.sel7 <= VPS_SEL7_RESET;
      state_q.sel8 <= VPS_SEL8_RESET;
      state_q.vout_sel <= VPS_VOUT_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // outputs
  assign capture5_input = state_q.routed[3];
  assign timer5_clock_input = state_q.routed[2];
  assign capture6_input = state_q.routed[1];
  assign timer6_clock_input = state_q.routed[0];
  // slave fabric sees master virtual output k as its input 170+k
  assign slave_fabric_virtual_in = state_q.slave_vin; // see [RQ4]

endmodule : vps_routing

`default_nettype wire

// ==== tb/vps_routing_sva.sv ====
// assertion checker for the virtual pin routing block
`timescale 1ns/1ps
`default_nettype none

module vps_routing_sva
  import vps_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus and pin sources
  input wire vps_pkg::vps_axil_m2s_type axil_m2s,
  input wire vps_pkg::vps_axil_s2m_type axil_s2m,
  input wire logic [VPS_INTERNAL_COUNT-1:0] core_internal_pin,
  input wire logic [VPS_VPIN_COUNT-1:0] slave_virtual_remap_output,
  // routed outputs
  input wire logic capture5_input,
  input wire logic timer5_clock_input,
  input wire logic capture6_input,
  input wire logic timer6_clock_input
);
  typedef struct packed {
    logic [15:0] sel7;
    logic [15:0] sel8;
  } vps_shadow_type;
  vps_shadow_type sh_d;
  vps_shadow_type sh_q;
  logic wr_go;
  logic [31:0] sels;
  logic [3:0] exp_v;
  logic [3:0] exp_ok;
  logic [15:0] wmask;

  // ==========================================================================
  // shadow selectors; only valid because the bench offers both write halves together
  function automatic logic pin_at(input logic [7:0] s, input logic [12:0] ci,
                                  input logic [5:0] sv);
    if (s >= 8'h01 && s <= 8'h0D) return ci[s-8'h01];
    if (s >= 8'hAA && s <= 8'hAF) return sv[s-8'hAA];
    return 1'b0;
  endfunction : pin_at

  // pads are left out as their timing is not one edge; master virtual pins as periph_out and the output selectors are not seen here
  function automatic logic known(input logic [7:0] s);
    return s <= 8'h0D || (s >= 8'hAA && s <= 8'hAF) || s >= 8'hB6;
  endfunction : known

  assign wr_go = axil_m2s.awvalid && axil_s2m.awready && axil_m2s.wvalid && axil_s2m.wready;

  // next shadow and expected routed levels
  always_comb begin
    sh_d = sh_q;
    // only strobed bytes reach the selectors
    wmask = {{8{axil_m2s.wstrb[1]}}, {8{axil_m2s.wstrb[0]}}};
    if (wr_go && axil_m2s.awaddr[7:2] == 6'h00) begin
      sh_d.sel7 = (sh_q.sel7 & ~wmask) | (axil_m2s.wdata[15:0] & wmask);
    end
    if (wr_go && axil_m2s.awaddr[7:2] == 6'h01) begin
      sh_d.sel8 = (sh_q.sel8 & ~wmask) | (axil_m2s.wdata[15:0] & wmask);
    end
    sels = {sh_q.sel7, sh_q.sel8};
    for (int i = 0; i < 4; i++) begin
      exp_v[i] = pin_at(sels[8*i +: 8], core_internal_pin, slave_virtual_remap_output);
      exp_ok[i] = known(sels[8*i +: 8]);
    end
  end

  // shadow register
  always_ff @(posedge aclk) begin
    if (!aresetn) sh_q <= '0;
    else sh_q <= sh_d;
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  cap5_route_a: assert property (exp_ok[3] |=> capture5_input == $past(exp_v[3]))
    else $error("capture 5 input does not follow its selector");
  tck5_route_a: assert property (exp_ok[2] |=> timer5_clock_input == $past(exp_v[2]))
    else $error("timer 5 clock input does not follow its selector");
  cap6_route_a: assert property (exp_ok[1] |=> capture6_input == $past(exp_v[1]))
    else $error("capture 6 input does not follow its selector");
  tck6_route_a: assert property (exp_ok[0] |=> timer6_clock_input == $past(exp_v[0]))
    else $error("timer 6 clock input does not follow its selector");
  wr_answer_a: assert property (wr_go |=> axil_s2m.bvalid)
    else $error("write response late");
  wr_block_a: assert property (axil_s2m.bvalid |-> !axil_s2m.awready && !axil_s2m.wready)
    else $error("write taken while response pending");
  wr_done_a: assert property (axil_s2m.bvalid && axil_m2s.bready |=> !axil_s2m.bvalid)
    else $error("write response outlived its handshake");
  rd_answer_a: assert property (axil_m2s.arvalid && axil_s2m.arready |=> axil_s2m.rvalid)
    else $error("read data late");
  rd_block_a: assert property (axil_s2m.rvalid |-> !axil_s2m.arready)
    else $error("read taken while data pending");
  rd_done_a: assert property (axil_s2m.rvalid && axil_m2s.rready |=> !axil_s2m.rvalid)
    else $error("read data outlived its handshake");

  cover property (wr_go && axil_m2s.awaddr[7:2] == 6'h00);
  cover property (exp_ok[3] && sh_q.sel7[15:8] == 8'hAF);
  cover property (axil_s2m.rvalid && axil_s2m.rresp == VPS_RESP_SLVERR);
endmodule : vps_routing_sva

bind vps_routing vps_routing_sva i_sva (
  .aclk(aclk),
  .aresetn(aresetn),
  .axil_m2s(axil_m2s),
  .axil_s2m(axil_s2m),
  .core_internal_pin(core_internal_pin),
  .slave_virtual_remap_output(slave_virtual_remap_output),
  .capture5_input(capture5_input),
  .timer5_clock_input(timer5_clock_input),
  .capture6_input(capture6_input),
  .timer6_clock_input(timer6_clock_input)
);

`default_nettype wire

// ==== tb/vps_far_model.sv ====
// model of the slave fabric: steady virtual outputs plus one serial transmitter
`timescale 1ns/1ps
`default_nettype none

module vps_far_model
  import vps_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench commands
  input wire logic [4:0] level_in,
  input wire logic [7:0] tx_byte,
  input wire logic tx_go,
  // slave virtual outputs 5..0
  output logic [VPS_VPIN_COUNT-1:0] slave_virtual_remap_output
);
  typedef struct packed {
    logic [8:0] shift;
    logic [3:0] cnt;
  } vps_far_type;
  vps_far_type far_d;
  vps_far_type far_q;

  // ==========================================================================
  // start bit then eight data bits, lsb first; line idles high like a real transmitter
  always_comb begin
    far_d = far_q;
    if (far_q.cnt != 4'h0) begin
      far_d.shift = {1'b1, far_q.shift[8:1]};
      far_d.cnt = far_q.cnt - 4'h1;
    end else if (tx_go) begin
      far_d.shift = {tx_byte, 1'b0};
      far_d.cnt = 4'h9;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) far_q <= '{shift: 9'h1FF, cnt: 4'h0};
    else far_q <= far_d;
  end

  // output 5 is the transmit line, outputs 4..0 are steady levels
  assign slave_virtual_remap_output = {far_q.shift[0], level_in};
endmodule : vps_far_model

`default_nettype wire

// ==== tb/vps_routing_tb.sv ====
// self-checking bench for the virtual pin routing block
`timescale 1ns/1ps
`default_nettype none

module vps_routing_tb;
  import vps_pkg::*;
  logic aclk;
  logic aresetn;
  vps_axil_m2s_type m2s;
  vps_axil_s2m_type s2m;
  logic [31:0] pads;
  logic [12:0] core_pins;
  logic [31:0] periph;
  logic [4:0] slave_lvl;
  logic [7:0] tx_byte;
  logic tx_go;
  logic [5:0] slave_vout;
  logic [5:0] fabric_in;
  logic cap5;
  logic tck5;
  logic cap6;
  logic tck6;
  logic [31:0] rd;
  logic [1:0] resp;
  logic [7:0] rx;
  int num_errors;
  int n_checks;
  int n;

  // ==========================================================================
  // design and far side
  vps_routing i_dut (.aclk(aclk), .aresetn(aresetn), .axil_m2s(m2s), .axil_s2m(s2m),
    .remappable_pin(pads), .core_internal_pin(core_pins), .periph_out(periph),
    .slave_virtual_remap_output(slave_vout), .slave_fabric_virtual_in(fabric_in),
    .capture5_input(cap5), .timer5_clock_input(tck5), .capture6_input(cap6),
    .timer6_clock_input(tck6));
  vps_far_model i_far (.aclk(aclk), .aresetn(aresetn), .level_in(slave_lvl),
    .tx_byte(tx_byte), .tx_go(tx_go), .slave_virtual_remap_output(slave_vout));

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ==========================================================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // both halves offered together, each released when taken; bready held until answered
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge aclk);
    m2s.awvalid <= 1'b1;
    m2s.awaddr <= a;
    m2s.wvalid <= 1'b1;
    m2s.wdata <= d;
    m2s.wstrb <= s;
    m2s.bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (m2s.awvalid && s2m.awready) m2s.awvalid <= 1'b0;
      if (m2s.wvalid && s2m.wready) m2s.wvalid <= 1'b0;
    end while (s2m.bvalid !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    resp = s2m.bresp;
    m2s.bready <= 1'b0;
  endtask : wr

  task automatic rdw(input logic [7:0] a);
    @(posedge aclk);
    m2s.arvalid <= 1'b1;
    m2s.araddr <= a;
    m2s.rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (m2s.arvalid && s2m.arready) m2s.arvalid <= 1'b0;
    end while (s2m.rvalid !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = s2m.rdata;
    resp = s2m.rresp;
    m2s.rready <= 1'b0;
  endtask : rdw

  // let the routed outputs settle before looking
  task automatic settle(input int c);
    repeat (c) @(posedge aclk);
    #1;
  endtask : settle

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #500000;
    num_errors++;
    end_of_test();
  end

  // ==========================================================================
  // tests
  initial begin
    m2s = '0;
    pads = '0;
    core_pins = '0;
    periph = '0;
    slave_lvl = '0;
    tx_byte = 8'h00;
    tx_go = 1'b0;
    num_errors = 0;
    n_checks = 0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, width, byte strobes, read-only and unmapped places
    rdw(VPS_OFS_SEL7);
    check(rd, 32'h0000_0000);
    rdw(VPS_OFS_SEL8);
    check(rd, 32'h0000_0000);
    wr(VPS_OFS_SEL8, 32'hFFFF_FFFF);
    check(resp, VPS_RESP_OKAY);
    rdw(VPS_OFS_SEL8);
    check(rd, 32'h0000_FFFF);
    // only the upper selector byte is strobed, the lower one must keep its value
    wr(VPS_OFS_SEL8, 32'h0000_1234, 4'h2);
    rdw(VPS_OFS_SEL8);
    check(rd, 32'h0000_12FF);
    // a reset in mid-run brings the selectors back to their reset value
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdw(VPS_OFS_SEL8);
    check(rd, 32'h0000_0000);
    wr(VPS_OFS_STATUS, 32'hFFFF_FFFF);
    check(resp, VPS_RESP_SLVERR);
    rdw(8'h40);
    check(rd, 32'h0000_0000);
    check(resp, VPS_RESP_SLVERR);
    // every internal index and every slave virtual index, one-hot except pin 175 (idle-high transmit line), so a wrong pick reads low
    for (int k = 1; k <= 13; k++) begin
      core_pins <= 13'h1 << (k - 1);
      slave_lvl <= 5'h1 << (k % 6);
      wr(VPS_OFS_SEL7, {16'h0, 8'(k), 8'(170 + k % 6)});
      settle(2);
      check(cap5, 1'b1);
      check(tck5, 1'b1);
    end
    // master virtual pins carry peripheral outputs into both fabrics
    wr(VPS_OFS_VOUT_LO, 32'h0403_0201);
    wr(VPS_OFS_VOUT_HI, 32'h0000_0605);
    for (int k = 0; k < 6; k++) begin
      periph <= 32'h1 << k;
      wr(VPS_OFS_SEL8, {16'h0, 8'(176 + k), 8'(181 - k)});
      settle(2);
      check(cap6, 1'b1);
      check(tck6, 1'b0);
      check(fabric_in, 6'h1 << k);
    end
    // status: slave copy and master virtual pins both 6'h20, routed levels 4'hE
    rdw(VPS_OFS_STATUS);
    check(rd, 32'h0000_820E);
    check(resp, VPS_RESP_OKAY);
    // pads reach pin 14 upward but never the virtual pins
    periph <= '0;
    pads <= '1;
    wr(VPS_OFS_SEL7, 32'h0000_0E2D);
    wr(VPS_OFS_SEL8, 32'h0000_B0B5);
    settle(4);
    check({cap5, tck5}, 2'b11);
    check({cap6, tck6, fabric_in}, 8'h00);
    // slave transmitter into the capture 5 receiver through pin 175
    wr(VPS_OFS_SEL7, 32'h0000_AF00);
    settle(2);
    check(cap5, 1'b1);
    @(posedge aclk);
    tx_byte <= 8'hA5;
    tx_go <= 1'b1;
    @(posedge aclk);
    tx_go <= 1'b0;
    n = 0;
    while (cap5 !== 1'b0 && n < 40) begin
      settle(1);
      n++;
    end
    for (int i = 0; i < 8; i++) begin
      settle(1);
      rx[i] = cap5;
    end
    check(rx, 8'hA5);
    end_of_test();
  end
endmodule : vps_routing_tb

`default_nettype wire
